/* File: design/motor_io_signal_control.sv */
// speed input, direction, fault and tachometer conditioning of a fan driver
// Operation
// - limit each target speed drop by table step
// - analog span maps to 0..512, polarity swaps
// - duty input high active, negative inverts first
// - analog command carries 9-bit resolution
// - duty resolution falls above 20 kHz
// - speed pin doubles as serial clock input
// - direction bit swaps pin-to-rotation mapping
// - fault pin open drain, pulls low on fault
// - three-line serial uses fault pin as data out
// - low-speed alarm after ten seconds below threshold
// - alarm clears above 70 percent of startup
// - alarm select and invert shape fault output
// - tacho pin shows pulses or lock or low-speed indication
// - tacho pin low 3 ms after power and wake
// - reverse rotation raises fault when enabled
// - fast faults reach fault pin at once
// - three-bit field sets pulses per pole pair
// - tacho released below 1 Hz hall rate
// - one-per-pair code 0 follows hall directly; code 7 runs the same rate through the pulse generator
// - tacho pin is serial data in or both ways
// - startup speed is a 12-bit rpm setting
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module motor_io_signal_control #(
    parameter int unsigned TACHO_HOLD = motor_io_pkg::TACHO_HOLD_CYCLES,
    parameter int unsigned LOW_SPEED_TIME = motor_io_pkg::LOW_SPEED_CYCLES,
    parameter int unsigned HALL_TIMEOUT = motor_io_pkg::HALL_TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register port
    input wire logic [motor_io_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [motor_io_pkg::DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [motor_io_pkg::DATA_WIDTH-1:0] reg_rdata,
    // speed command
    input wire logic speed_command_pin,
    input wire logic [motor_io_pkg::ADC_WIDTH-1:0] analog_level,
    output logic [motor_io_pkg::COMMAND_WIDTH-1:0] speed_command,
    // target speed limiter
    input wire logic [motor_io_pkg::SPEED_WIDTH-1:0] target_request,
    input wire logic target_valid,
    output logic [motor_io_pkg::SPEED_WIDTH-1:0] target_speed,
    // direction
    input wire logic direction_pin,
    output logic rotate_ccw,
    // motor state and faults
    input wire logic hall_positive_input,
    input wire logic [motor_io_pkg::SPEED_WIDTH-1:0] rotation_speed,
    input wire logic motor_lock,
    input wire logic reverse_rotation,
    input wire logic charge_pump_low,
    input wire logic overcurrent_shutdown,
    input wire logic thermal_shutdown,
    input wire logic standby_mode,
    // serial interface sharing
    input wire logic serial_active,
    input wire logic serial_data_out,
    input wire logic serial_io_drive,
    output logic serial_clock,
    output logic serial_data_in,
    // fault pin, open drain
    output logic fault_pin_out,
    output logic fault_pin_oe,
    // tacho pin, open drain
    input wire logic tacho_pin_in,
    output logic tacho_pin_out,
    output logic tacho_pin_oe
);
    import motor_io_pkg::*;

    logic [CONFIG_WIDTH-1:0] config_bits;
    logic [STARTUP_WIDTH-1:0] startup_speed_setting;
    logic analog_mode, negative_polarity, dir_map, alarm_source_select;
    logic alert_invert, tacho_output_select;
    logic reverse_rotation_alert_enable, three_line_mode;
    logic [2:0] pulse_rate_select, speed_drop_step_limit;

    assign analog_mode = config_bits[CFG_ANALOG];
    assign negative_polarity = config_bits[CFG_NEGATIVE];
    assign dir_map = config_bits[CFG_DIR_MAP];
    assign alarm_source_select = config_bits[CFG_ALARM_SEL];
    assign alert_invert = config_bits[CFG_ALERT_INV];
    assign tacho_output_select = config_bits[CFG_TACHO_SEL];
    assign reverse_rotation_alert_enable = config_bits[CFG_REV_ALERT];
    assign three_line_mode = config_bits[CFG_THREE_LINE];
    assign pulse_rate_select = config_bits[CFG_RATE_LSB +: 3];
    assign speed_drop_step_limit = config_bits[CFG_STEP_LSB +: 3];

    function automatic logic [SPEED_WIDTH-1:0] step_of(logic [2:0] code);
        unique case (code)
            3'h0: step_of = 14'h0000;
            3'h1: step_of = 14'h0200;
            3'h2: step_of = 14'h0898;
            3'h3: step_of = 14'h0ED8;
            3'h4: step_of = 14'h1518;
            3'h5: step_of = 14'h1B58;
            3'h6: step_of = 14'h2198;
            3'h7: step_of = 14'h2800;
        endcase
    endfunction : step_of

    // returns {numerator, denominator} of pulses per pole pair
    function automatic logic [7:0] rate_of(logic [2:0] code);
        unique case (code)
            3'h1: rate_of = 8'h23;
            3'h2: rate_of = 8'h12;
            3'h3: rate_of = 8'h21;
            3'h4: rate_of = 8'h31;
            3'h5: rate_of = 8'hC5;
            3'h6: rate_of = 8'h13;
            default: rate_of = 8'h11;
        endcase
    endfunction : rate_of

    // returns {detect enable, threshold rpm}
    function automatic logic [STARTUP_WIDTH:0] slow_limit(
        logic [STARTUP_WIDTH-1:0] start);
        if (start >= SLOW_HIGH_RPM) begin
            slow_limit = {1'b1, 1'b0, start[STARTUP_WIDTH-1:1]};
        end else if (start >= SLOW_MID_RPM) begin
            slow_limit = {1'b1, start - SLOW_OFFSET_RPM};
        end else if (start >= SLOW_MIN_RPM) begin
            slow_limit = {1'b1, SLOW_FIXED_RPM};
        end else begin
            slow_limit = '0;
        end
    endfunction : slow_limit

    // register writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            config_bits <= CONFIG_RESET;
            startup_speed_setting <= STARTUP_RESET;
        end else if (reg_write) begin
            if (reg_addr == CONFIG_OFFSET) begin
                config_bits <= reg_wdata[CONFIG_WIDTH-1:0];
            end
            if (reg_addr == STARTUP_OFFSET) begin
                startup_speed_setting <= reg_wdata[STARTUP_WIDTH-1:0];
            end
        end
    end

    logic low_speed, alert_event, tach_hold, hall_valid;

    // register reads, data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                CONFIG_OFFSET: reg_rdata <= 32'(config_bits);
                STARTUP_OFFSET: reg_rdata <= 32'(startup_speed_setting);
                STATUS_OFFSET: reg_rdata <= 32'({rotate_ccw, hall_valid,
                    tach_hold, alert_event, motor_lock, low_speed});
                COMMAND_OFFSET: reg_rdata <= 32'(speed_command);
                TARGET_OFFSET: reg_rdata <= 32'(target_speed);
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // duty sampling at a reduced rate sets the resolution roll-off
    logic [3:0] sample_div;
    logic sample_tick, pwm_level, pwm_prev, pwm_idle;
    logic [COUNT_WIDTH-1:0] high_count, period_count;
    assign sample_tick = (sample_div == 4'(PWM_SAMPLE_DIV - 1));
    assign pwm_level = speed_command_pin ^ negative_polarity;
    assign pwm_idle = (period_count == COUNT_WIDTH'(PWM_TIMEOUT_SAMPLES));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sample_div <= '0;
        end else begin
            sample_div <= sample_tick ? 4'h0 : sample_div + 4'h1;
        end
    end

    divide_state_type div_state;
    logic [COUNT_WIDTH+DUTY_SHIFT-1:0] div_rem;
    logic [COUNT_WIDTH-1:0] div_den;
    logic [COMMAND_WIDTH-1:0] div_quot;
    logic [3:0] div_bit;
    logic start_divide;
    logic [COUNT_WIDTH+DUTY_SHIFT-1:0] div_trial;
    assign start_divide = sample_tick && pwm_level && !pwm_prev
        && period_count != '0;
    assign div_trial = (COUNT_WIDTH+DUTY_SHIFT)'(div_den) << div_bit;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwm_prev <= 1'b0;
            high_count <= '0;
            period_count <= '0;
        end else if (sample_tick) begin
            pwm_prev <= pwm_level;
            if (start_divide) begin
                high_count <= COUNT_WIDTH'(1);
                period_count <= COUNT_WIDTH'(1);
            end else if (!pwm_idle) begin
                period_count <= period_count + 1'b1;
                high_count <= high_count + COUNT_WIDTH'(pwm_level);
            end
        end
    end

    // duty = high * 512 / period, one quotient bit per clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_state <= DIV_IDLE;
            div_rem <= '0;
            div_den <= '0;
            div_quot <= '0;
            div_bit <= '0;
        end else begin
            unique case (div_state)
                DIV_IDLE: begin
                    if (start_divide) begin
                        div_rem <= {high_count, DUTY_SHIFT'(0)};
                        div_den <= period_count;
                        div_quot <= '0;
                        div_bit <= 4'(COMMAND_WIDTH - 1);
                        div_state <= DIV_BUSY;
                    end
                end
                DIV_BUSY: begin
                    if (div_rem >= div_trial) begin
                        div_rem <= div_rem - div_trial;
                        div_quot[div_bit] <= 1'b1;
                    end
                    if (div_bit == '0) begin
                        div_state <= DIV_IDLE;
                    end
                    div_bit <= div_bit - 4'h1;
                end
            endcase
        end
    end

    logic div_done;
    assign div_done = (div_state == DIV_BUSY) && (div_bit == '0);

    // speed command, frozen while the pin carries the serial clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            speed_command <= '0;
        end else if (serial_active) begin
            speed_command <= speed_command;
        end else if (analog_mode) begin
            if (analog_level == ADC_TOP) begin
                speed_command <= negative_polarity ? '0 : COMMAND_FULL;
            end else if (negative_polarity) begin
                speed_command <= COMMAND_FULL - COMMAND_WIDTH'(analog_level);
            end else begin
                speed_command <= COMMAND_WIDTH'(analog_level);
            end
        end else if (pwm_idle) begin
            speed_command <= pwm_level ? COMMAND_FULL : '0;
        end else if (div_done) begin
            speed_command <= div_quot[0] || div_rem >= div_trial
                ? div_quot | COMMAND_WIDTH'(1) : div_quot;
        end
    end

    // target speed with limited downward step
    logic [SPEED_WIDTH-1:0] step_value;
    logic limit_drop;
    assign step_value = step_of(speed_drop_step_limit);
    assign limit_drop = (speed_drop_step_limit != 3'h0)
        && ((SPEED_WIDTH+1)'(target_request) + (SPEED_WIDTH+1)'(step_value)
            < (SPEED_WIDTH+1)'(target_speed));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            target_speed <= '0;
        end else if (target_valid) begin
            target_speed <= limit_drop ? target_speed - step_value
                : target_request;
        end
    end

    // direction and serial sharing outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rotate_ccw <= 1'b0;
            serial_clock <= 1'b0;
            serial_data_in <= 1'b0;
        end else begin
            rotate_ccw <= direction_pin ^ dir_map;
            serial_clock <= speed_command_pin;
            serial_data_in <= tacho_pin_in;
        end
    end

    // low-speed alarm
    logic [STARTUP_WIDTH:0] slow_cfg;
    logic below_limit, above_release;
    logic [31:0] slow_count;
    assign slow_cfg = slow_limit(startup_speed_setting);
    assign below_limit = slow_cfg[STARTUP_WIDTH]
        && rotation_speed < SPEED_WIDTH'(slow_cfg[STARTUP_WIDTH-1:0]);
    assign above_release = 18'(rotation_speed) * 18'(RELEASE_DEN)
        > 18'(startup_speed_setting) * 18'(RELEASE_NUM);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            slow_count <= '0;
            low_speed <= 1'b0;
        end else begin
            if (!below_limit) begin
                slow_count <= '0;
            end else if (slow_count != 32'(LOW_SPEED_TIME)) begin
                slow_count <= slow_count + 32'h1;
            end
            if (below_limit && slow_count == 32'(LOW_SPEED_TIME)) begin
                low_speed <= 1'b1;
            end else if (above_release) begin
                low_speed <= 1'b0;
            end
        end
    end

    // fault pin
    logic fault_pull;
    assign alert_event = (alarm_source_select ? low_speed : motor_lock)
        | charge_pump_low | overcurrent_shutdown | thermal_shutdown
        | (reverse_rotation_alert_enable & reverse_rotation);
    assign fault_pull = alert_invert ? !alert_event : alert_event;
    assign fault_pin_out = 1'b0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault_pin_oe <= 1'b0;
        end else if (serial_active && three_line_mode) begin
            fault_pin_oe <= !serial_data_out;
        end else begin
            fault_pin_oe <= fault_pull;
        end
    end

    // tacho hold after power-on and standby wake
    logic [31:0] hold_count;
    logic standby_prev;
    assign tach_hold = (hold_count != '0);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hold_count <= 32'(TACHO_HOLD);
            standby_prev <= 1'b0;
        end else begin
            standby_prev <= standby_mode;
            if (standby_prev && !standby_mode) begin
                hold_count <= 32'(TACHO_HOLD);
            end else if (tach_hold) begin
                hold_count <= hold_count - 32'h1;
            end
        end
    end

    // hall period and presence
    logic hall_level, hall_prev, hall_rise;
    logic [31:0] hall_count, hall_period;
    assign hall_rise = hall_level && !hall_prev;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hall_level <= 1'b0;
            hall_prev <= 1'b0;
            hall_count <= '0;
            hall_period <= '0;
            hall_valid <= 1'b0;
        end else begin
            hall_level <= hall_positive_input;
            hall_prev <= hall_level;
            if (hall_rise) begin
                hall_period <= hall_count + 32'h1;
                hall_count <= '0;
                hall_valid <= (hall_count < 32'(HALL_TIMEOUT));
            end else if (hall_count != 32'(HALL_TIMEOUT)) begin
                hall_count <= hall_count + 32'h1;
            end else begin
                hall_valid <= 1'b0;
            end
        end
    end

    // scaled pulse train: 2*num toggles per den hall periods
    logic [7:0] rate;
    logic [34:0] scaled_period, next_acc;
    logic [34:0] pulse_acc;
    logic pulse_level;
    assign rate = rate_of(pulse_rate_select);
    assign scaled_period = 35'(hall_period) * 35'(rate[3:0]);
    assign next_acc = pulse_acc + 35'({rate[7:4], 1'b0});

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pulse_acc <= '0;
            pulse_level <= 1'b0;
        end else if (!hall_valid) begin
            pulse_acc <= '0;
            pulse_level <= 1'b0;
        end else if (next_acc >= scaled_period) begin
            pulse_acc <= next_acc - scaled_period;
            pulse_level <= !pulse_level;
        end else begin
            pulse_acc <= next_acc;
        end
    end

    // tacho pin drive
    logic tacho_level;
    assign tacho_level = (pulse_rate_select == 3'h0)
        ? hall_level : pulse_level;
    assign tacho_pin_out = 1'b0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tacho_pin_oe <= 1'b1;
        end else if (serial_active) begin
            tacho_pin_oe <= !three_line_mode && serial_io_drive
                && !serial_data_out;
        end else if (tach_hold) begin
            tacho_pin_oe <= 1'b1;
        end else if (tacho_output_select) begin
            tacho_pin_oe <= alarm_source_select
                ? low_speed : motor_lock;
        end else begin
            tacho_pin_oe <= hall_valid && !tacho_level;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_step_drop_limit: assert property (target_valid && limit_drop
        |=> target_speed == $past(target_speed) - $past(step_value))
        else $error("target dropped by more than the step");
    a_analog_negative: assert property (analog_mode && negative_polarity
        && !serial_active && analog_level == '0
        |=> speed_command == COMMAND_FULL)
        else $error("negative analog low end not full scale");
    a_duty_polarity: assert property (!analog_mode && pwm_idle
        && !serial_active && !speed_command_pin && negative_polarity
        |=> speed_command == COMMAND_FULL)
        else $error("inverted idle duty input not full scale");
    a_serial_hold: assert property (serial_active
        |=> $stable(speed_command))
        else $error("speed command moved during serial access");
    a_direction_map: assert property (##1 rotate_ccw
        == ($past(direction_pin) ^ $past(dir_map)))
        else $error("rotation direction mapping wrong");
    a_fault_thermal: assert property (thermal_shutdown && !alert_invert
        && !serial_active |=> fault_pin_oe && !fault_pin_out)
        else $error("thermal fault did not pull fault pin");
    a_fault_serial: assert property (serial_active && three_line_mode
        |=> fault_pin_oe == !$past(serial_data_out))
        else $error("fault pin not carrying serial data");
    a_slow_release: assert property (low_speed && above_release
        && !below_limit |=> !low_speed)
        else $error("low-speed alarm not released");
    a_tacho_hold: assert property (tach_hold && !serial_active
        |=> tacho_pin_oe)
        else $error("tacho pin released during hold");
    a_tacho_idle: assert property (!hall_valid && !tach_hold
        && !tacho_output_select && !serial_active |=> !tacho_pin_oe)
        else $error("tacho pin driven without hall signal");
    a_tacho_follow: assert property (hall_valid && !tach_hold
        && pulse_rate_select == 3'h0 && !tacho_output_select
        && !serial_active |=> tacho_pin_oe == !$past(hall_level))
        else $error("tacho pin not following hall");

    c_slow_alarm: cover property ($rose(low_speed));
    c_step_limit: cover property (target_valid && limit_drop);
    c_pulse_rate: cover property (hall_valid && pulse_rate_select == 3'h4
        && $changed(pulse_level));
    c_duty_done: cover property (div_done && !analog_mode);
endmodule : motor_io_signal_control

/* File: design/motor_io_pkg.sv */
// constants, register map and types of the motor signal-conditioning block
package motor_io_pkg;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int SPEED_WIDTH = 14;
    localparam int STARTUP_WIDTH = 12;
    localparam int COMMAND_WIDTH = 10;
    localparam int ADC_WIDTH = 9;
    localparam int COUNT_WIDTH = 15;

    // register byte offsets
    localparam logic [ADDR_WIDTH-1:0] CONFIG_OFFSET = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] STARTUP_OFFSET = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] COMMAND_OFFSET = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] TARGET_OFFSET = 8'h10;

    // configuration fields
    localparam int CONFIG_WIDTH = 14;
    localparam int CFG_ANALOG = 0;
    localparam int CFG_NEGATIVE = 1;
    localparam int CFG_DIR_MAP = 2;
    localparam int CFG_ALARM_SEL = 3;
    localparam int CFG_ALERT_INV = 4;
    localparam int CFG_TACHO_SEL = 5;
    localparam int CFG_REV_ALERT = 6;
    localparam int CFG_THREE_LINE = 7;
    localparam int CFG_RATE_LSB = 8;
    localparam int CFG_STEP_LSB = 11;
    localparam logic [CONFIG_WIDTH-1:0] CONFIG_RESET = 14'h0000;
    localparam logic [STARTUP_WIDTH-1:0] STARTUP_RESET = 12'h000;

    // timing
    localparam int CLOCK_KHZ = 100000;
    localparam int TACHO_HOLD_MS = 3;
    localparam int TACHO_HOLD_CYCLES = TACHO_HOLD_MS * CLOCK_KHZ;
    localparam int LOW_SPEED_S = 10;
    localparam int LOW_SPEED_CYCLES = LOW_SPEED_S * CLOCK_KHZ * 1000;
    localparam int HALL_MIN_HZ = 1;
    localparam int HALL_TIMEOUT_CYCLES = CLOCK_KHZ * 1000 / HALL_MIN_HZ;
    localparam int PWM_SAMPLE_DIV = 10;
    localparam int PWM_MIN_KHZ = 1;
    localparam int PWM_TIMEOUT_SAMPLES =
        2 * CLOCK_KHZ / (PWM_SAMPLE_DIV * PWM_MIN_KHZ);

    // speed command scale
    localparam logic [COMMAND_WIDTH-1:0] COMMAND_FULL = 10'h200;
    localparam logic [ADC_WIDTH-1:0] ADC_TOP = 9'h1FF;
    localparam int DUTY_SHIFT = 9;

    // low-speed alarm thresholds in rpm, release as a ratio of startup speed
    localparam logic [STARTUP_WIDTH-1:0] SLOW_HIGH_RPM = 12'h3E8;
    localparam logic [STARTUP_WIDTH-1:0] SLOW_MID_RPM = 12'h2BC;
    localparam logic [STARTUP_WIDTH-1:0] SLOW_MIN_RPM = 12'h120;
    localparam logic [STARTUP_WIDTH-1:0] SLOW_OFFSET_RPM = 12'h1F4;
    localparam logic [STARTUP_WIDTH-1:0] SLOW_FIXED_RPM = 12'h0C8;
    localparam int RELEASE_NUM = 7;
    localparam int RELEASE_DEN = 10;

    typedef enum logic {DIV_IDLE, DIV_BUSY} divide_state_type;
endpackage : motor_io_pkg

/* File: tb/motor_host_model.sv */
// host side: duty-cycle speed source and pulled-up tacho wire
`timescale 1ns/1ns
module motor_host_model #(
    parameter int PERIOD = 5000,
    parameter int HIGH = 1250
) (
    // clock and control
    input wire logic clock,
    input wire logic pwm_run,
    // pins
    input wire logic tacho_pin_oe,
    output logic speed_command_pin,
    output logic tacho_pin_in
);
    int n = 0;
    always @(posedge clock) n <= (n + 1) % PERIOD;
    // 20 kHz duty source, idle low outside runs
    assign speed_command_pin = pwm_run && n < HIGH;
    assign tacho_pin_in = !tacho_pin_oe;
endmodule : motor_host_model

/* File: tb/motor_io_signal_control_tb_top.sv */
// self-checking bench of the motor signal-conditioning block
`timescale 1ns/1ns
module motor_io_signal_control_tb_top;
    import motor_io_pkg::*;
    logic clock = 0, rst_b = 0, reg_write = 0, reg_read = 0, pwm_run = 0;
    logic [ADDR_WIDTH-1:0] reg_addr = 8'h00;
    logic [DATA_WIDTH-1:0] reg_wdata = 32'h0, reg_rdata;
    logic speed_command_pin, target_valid = 0, direction_pin = 0;
    logic [ADC_WIDTH-1:0] analog_level = 9'h000;
    logic [COMMAND_WIDTH-1:0] speed_command;
    logic [SPEED_WIDTH-1:0] target_request = 14'h0, target_speed;
    logic [SPEED_WIDTH-1:0] rotation_speed = 14'h3FFF;
    logic rotate_ccw, hall_positive_input = 0, motor_lock = 0;
    logic reverse_rotation = 0, charge_pump_low = 0, overcurrent_shutdown = 0;
    logic thermal_shutdown = 0, standby_mode = 0, serial_active = 0;
    logic serial_data_out = 1, serial_io_drive = 0, serial_clock;
    logic serial_data_in, fault_pin_out, fault_pin_oe, tacho_pin_in;
    logic tacho_pin_out, tacho_pin_oe;
    int fail_count = 0, check_count = 0;
    int steps [8] = '{0, 512, 2200, 3800, 5400, 7000, 8600, 10240};
    always #5 clock = ~clock;
    motor_io_signal_control #(.TACHO_HOLD(20), .LOW_SPEED_TIME(50),
        .HALL_TIMEOUT(200)) u_dut (.*);
    motor_host_model u_host (.*);
    function automatic logic [13:0] lim(input int cur, req, s);
        return 14'((s != 0 && req + s < cur) ? cur - s : req);
    endfunction : lim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_write <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_read <= 0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic tgt(input logic [13:0] r);
        @(posedge clock);
        {target_valid, target_request} <= {1'b1, r};
        @(posedge clock);
        target_valid <= 0;
    endtask : tgt
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        stop_test;
    end
    initial begin
        logic [13:0] r;
        void'($urandom(32'h17CA));
        tick(2);
        rst_b <= 1;
        tick(5);
        #1 chk(tacho_pin_oe, 1);
        tick(30);
        #1 chk(tacho_pin_oe, 0);
        rd(STARTUP_OFFSET, 0);
        wr(STARTUP_OFFSET, 32'h3E8);
        rd(STARTUP_OFFSET, 32'h3E8);
        rd(8'h14, 0);
        for (int k = 0; k < 8; k++) begin
            wr(CONFIG_OFFSET, k << 11);
            tgt(14'h3FFF);
            r = 14'($urandom);
            tgt(r);
            #1 chk(target_speed, lim(16383, r, steps[k]));
            rd(TARGET_OFFSET, lim(16383, r, steps[k]));
        end
        for (int i = 0; i < 4; i++) begin
            wr(CONFIG_OFFSET, (i >> 1) << 2);
            direction_pin <= i[0];
            tick(2);
            #1 chk(rotate_ccw, i[0] ^ i[1]);
        end
        $display("test limiter and direction done");
        wr(CONFIG_OFFSET, 1);
        analog_level <= 9'h1FF;
        tick(2);
        #1 chk(speed_command, 512);
        wr(CONFIG_OFFSET, 3);
        tick(2);
        #1 chk(speed_command, 0);
        tick(1);
        analog_level <= 9'h000;
        tick(2);
        #1 chk(speed_command, 512);
        wr(CONFIG_OFFSET, 0);
        pwm_run <= 1;
        tick(15000);
        #1 chk(speed_command, 128);
        wr(CONFIG_OFFSET, 2);
        tick(15000);
        #1 chk(speed_command, 384);
        $display("test speed command done");
        wr(CONFIG_OFFSET, 32'h20);
        motor_lock <= 1;
        tick(2);
        #1 chk(fault_pin_oe, 1);
        chk(tacho_pin_oe, 1);
        for (int c = 0; c < 4; c++) begin
            wr(CONFIG_OFFSET, c << 3);
            tick(2);
            #1 chk(fault_pin_oe, !c[0] ^ c[1]);
        end
        wr(CONFIG_OFFSET, 32'h8);
        for (int j = 0; j < 3; j++) begin
            tick(1);
            {charge_pump_low, overcurrent_shutdown, thermal_shutdown}
                <= 3'(1 << j);
            tick(2);
            #1 chk(fault_pin_oe, 1);
        end
        wr(CONFIG_OFFSET, 32'h48);
        {charge_pump_low, overcurrent_shutdown, thermal_shutdown} <= 3'h0;
        reverse_rotation <= 1;
        tick(2);
        #1 chk(fault_pin_oe, 1);
        tick(1);
        rotation_speed <= 14'd499;
        reverse_rotation <= 0;
        tick(60);
        #1 chk(fault_pin_oe, 1);
        wr(CONFIG_OFFSET, 32'h8);
        rotation_speed <= 14'd701;
        tick(3);
        #1 chk(fault_pin_oe, 0);
        for (int h = 0; h < 9; h++) begin
            tick(1);
            hall_positive_input <= h[0];
            tick(19);
            #1 chk(tacho_pin_oe, h > 3 && !h[0]);
        end
        rd(STATUS_OFFSET, 32'h32);
        tick(220);
        #1 chk(tacho_pin_oe, 0);
        tick(1);
        standby_mode <= 1;
        tick(1);
        standby_mode <= 0;
        tick(5);
        #1 chk(tacho_pin_oe, 1);
        wr(CONFIG_OFFSET, 32'h80);
        {serial_active, serial_data_out} <= 2'b10;
        tick(2);
        #1 chk(fault_pin_oe, 1);
        chk(tacho_pin_oe, 0);
        chk(serial_data_in, 1);
        $display("test fault and tacho done");
        stop_test;
    end
endmodule : motor_io_signal_control_tb_top
